//--- bench/scsm_cache_model.sv
`timescale 1ns/1ps
`default_nettype none
module scsm_cache_model (
  input  wire logic        clk,
  input  wire logic [15:0] shared_address,
  input  wire logic [1:0]  upper_bank_low_address,
  input  wire logic [1:0]  lower_bank_low_address,
  input  wire logic        addr_latch_enable,
  input  wire logic        bank_low_chip_enable_n,
  input  wire logic        bank_high_chip_enable_n,
  input  wire logic        bank_low_output_enable_n,
  input  wire logic        bank_high_output_enable_n,
  input  wire logic [3:0]  byte_write_enable_n,
  input  wire logic [31:0] cache_data_o,
  output logic      [31:0] cache_data_i,
  input  wire logic        tag_chip_enable_n,
  input  wire logic        tag_write_enable_n,
  input  wire logic        tag_output_enable_n,
  input  wire logic [8:0]  tag_data_o,
  output logic      [8:0]  tag_data_i,
  input  wire logic        valid_bit_o,
  output logic             valid_bit_i,
  input  wire logic        modified_chip_enable_n,
  input  wire logic        modified_write_enable_n,
  input  wire logic        modified_data_in,
  output logic             modified_data_out
);
  logic [31:0] dm [128];
  logic [10:0] tm [16];
  logic [15:0] la;
  logic [1:0]  lh, ll;
  logic [31:0] dq = '0;
  logic [10:0] tq = '0;
  logic        hi, sel, rd, tr, mr;
  logic [6:0]  ix;
  always_latch begin
    if (addr_latch_enable) begin
      la <= shared_address;
      lh <= upper_bank_low_address;
      ll <= lower_bank_low_address;
    end
  end
  assign hi = !bank_high_chip_enable_n;
  assign sel = !(bank_low_chip_enable_n && bank_high_chip_enable_n);
  assign ix = {hi, hi ? lh : ll, la[3:0]};
  assign rd = sel && &byte_write_enable_n &&
    (hi ? !bank_high_output_enable_n : !bank_low_output_enable_n);
  assign tr = !tag_chip_enable_n && !tag_output_enable_n && tag_write_enable_n;
  assign mr = !modified_chip_enable_n && modified_write_enable_n;
  // released lines show the inverse of the last value, never a stale copy
  assign cache_data_i = rd ? dm[ix] : ~dq;
  assign {valid_bit_i, tag_data_i} = tr ? tm[la[3:0]][9:0] : ~tq[9:0];
  assign modified_data_out = mr ? tm[la[3:0]][10] : ~tq[10];
  // plain always: dq and tq carry start values, which an always_ff may not share
  always @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (sel && !byte_write_enable_n[b]) begin
        dm[ix][8*b +: 8] <= cache_data_o[8*b +: 8];
      end
    end
    if (!tag_chip_enable_n && !tag_write_enable_n) begin
      tm[la[3:0]][9:0] <= {valid_bit_o, tag_data_o};
    end
    if (!modified_chip_enable_n && !modified_write_enable_n) begin
      tm[la[3:0]][10] <= modified_data_in;
    end
    if (rd) dq <= dm[ix];
    if (tr || mr) tq <= tm[la[3:0]];
  end
endmodule
`default_nettype wire

//--- bench/scsm_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scsm_ctrl_monitor (
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire logic                     data_req_valid,
  input wire logic                     data_req_ready,
  input wire scsm_pkg::scsm_data_req_t data_req,
  input wire logic                     data_rsp_valid,
  input wire logic [4:0]               presence_detect,
  input wire scsm_pkg::scsm_cfg_t      cfg,
  input wire logic                     addr_latch_enable,
  input wire logic                     bank_low_chip_enable_n,
  input wire logic                     bank_high_chip_enable_n,
  input wire logic                     bank_low_output_enable_n,
  input wire logic [3:0]               byte_write_enable_n,
  input wire logic                     cache_data_oe,
  input wire logic                     tag_chip_enable_n,
  input wire logic                     tag_write_enable_n,
  input wire logic                     tag_output_enable_n,
  input wire logic                     tag_data_oe,
  input wire logic                     valid_bit_oe,
  input wire logic                     modified_chip_enable_n,
  input wire logic                     modified_write_enable_n
);
  import scsm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic tk;
  assign tk = data_req_valid && data_req_ready;
  // response registers as the single strobe clock ends, seen three edges after take
  rsp_lat_a: assert property (tk |-> ##3 data_rsp_valid)
    else $error("data response not three cycles after take");
  byte_we_a: assert property (tk && data_req.write |-> ##2
    (byte_write_enable_n == ~$past(data_req.byte_en, 2))) else $error("byte strobes wrong");
  read_quiet_a: assert property (tk && !data_req.write |->
    ##2 (&byte_write_enable_n && !cache_data_oe) [*2]) else $error("read drove or wrote");
  bank_one_a: assert property (bank_low_chip_enable_n || bank_high_chip_enable_n)
    else $error("both banks enabled");
  oe_with_ce_a: assert property (!bank_low_output_enable_n |->
    !bank_low_chip_enable_n && !cache_data_oe) else $error("output enable without select");
  write_drive_a: assert property (!(&byte_write_enable_n) |->
    cache_data_oe && bank_low_output_enable_n) else $error("write without driven data");
  tag_read_a: assert property (!tag_output_enable_n |->
    !tag_chip_enable_n && tag_write_enable_n && !tag_data_oe) else $error("tag read bad");
  tag_drive_a: assert property (!tag_write_enable_n |->
    tag_data_oe && valid_bit_oe) else $error("tag write without driven lines");
  dirty_we_a: assert property (!modified_write_enable_n |-> !modified_chip_enable_n)
    else $error("dirty write without select");
  ale_hold_a: assert property (!(bank_low_chip_enable_n && bank_high_chip_enable_n)
    |-> !addr_latch_enable) else $error("address latch open during access");
  cfg_none_a: assert property (!presence_detect[4] |=> cfg == '0)
    else $error("config not cleared without module");
  cover property (tk && data_req.write);
  cover property (!bank_low_output_enable_n);
  cover property (!tag_write_enable_n);
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scsm_pkg::*;
  logic clk, reset_n, data_req_valid, data_req_ready, data_rsp_valid, tag_req_valid;
  logic tag_req_ready, tag_rsp_valid, tag_rsp_valid_bit, tag_rsp_modified, cache_data_oe;
  logic addr_latch_enable, bank_low_chip_enable_n, bank_high_chip_enable_n, tag_data_oe;
  logic bank_low_output_enable_n, bank_high_output_enable_n, tag_chip_enable_n;
  logic tag_write_enable_n, tag_output_enable_n, valid_bit_i, valid_bit_o, valid_bit_oe;
  logic modified_chip_enable_n, modified_write_enable_n, modified_data_in, modified_data_out;
  logic [31:0]    data_rsp_rdata, cache_data_i, cache_data_o;
  logic [15:0]    tag_req_addr, shared_address;
  logic [8:0]     tag_rsp_tag, tag_data_i, tag_data_o;
  logic [4:0]     presence_detect;
  logic [3:0]     byte_write_enable_n;
  logic [1:0]     upper_bank_low_address, lower_bank_low_address;
  scsm_data_req_t data_req;
  scsm_tag_req_t  tag_req;
  scsm_cfg_t      cfg;
  int             n_fail, checks;
  scsm_ctrl u_scsm_ctrl (.*);
  scsm_cache_model u_scsm_cache_model (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return data_req_ready;
      1: return data_rsp_valid;
      2: return tag_req_ready;
      default: return tag_rsp_valid;
    endcase
  endfunction
  // bounded wait on a handshake, sampled at falling edges
  task automatic wt(input int k);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic dop(input logic w, input logic h, input logic [15:0] a,
                     input logic [1:0] lo, input logic [3:0] be, input logic [31:0] wd);
    data_req = '{wdata: wd, addr: a, addr_lo: lo, byte_en: be, bank_high: h, write: w};
    data_req_valid = 1'b1;
    wt(0);
    @(negedge clk);
    data_req_valid = 1'b0;
    wt(1);
    chk({31'h0, data_rsp_valid}, 32'h1);
  endtask
  task automatic top(input logic w, input logic [15:0] a, input logic [8:0] t,
                     input logic v, input logic m);
    tag_req = '{tag: t, valid: v, modified: m, write: w};
    tag_req_addr = a;
    tag_req_valid = 1'b1;
    wt(2);
    @(negedge clk);
    tag_req_valid = 1'b0;
    wt(3);
    chk({31'h0, tag_rsp_valid}, 32'h1);
  endtask
  task automatic t_cfg;
    logic [1:0] s, m, w;
    data_req_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk({25'h0, cfg}, 32'h0);
    chk({31'h0, data_req_ready}, 32'h0);
    data_req_valid = 1'b0;
    for (int i = 0; i < 6; i++) begin
      s = (i < 3) ? 2'h1 : 2'h2;
      m = 2'(i % 3);
      w = (m == 2'h0) ? 2'h1 : ((m == 2'h1) ? 2'h0 : 2'h2);
      presence_detect = {1'b1, m == 2'h0, m == 2'h2, s == 2'h2, s == 2'h1};
      repeat (2) @(negedge clk);
      chk({25'h0, cfg}, {25'h0, s, m, w, 1'b1});
    end
    // both size and both memory lines tied: unmatched codes, widest tag
    presence_detect = 5'h1f;
    repeat (2) @(negedge clk);
    chk({25'h0, cfg}, 32'h7d);
    // fitted line open wipes whatever the other lines say
    presence_detect = 5'h0f;
    repeat (2) @(negedge clk);
    chk({25'h0, cfg}, 32'h0);
    presence_detect = 5'h16;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_data;
    dop(1'b1, 1'b0, 16'h1234, 2'h2, 4'hf, 32'ha5a5_5a5a);
    dop(1'b1, 1'b1, 16'h1234, 2'h2, 4'hf, 32'h0f1e_2d3c);
    dop(1'b1, 1'b0, 16'h1234, 2'h1, 4'hf, 32'h7777_0000);
    dop(1'b0, 1'b0, 16'h1234, 2'h2, 4'h0, 32'h0);
    chk(data_rsp_rdata, 32'ha5a5_5a5a);
    dop(1'b0, 1'b1, 16'h1234, 2'h2, 4'h0, 32'h0);
    chk(data_rsp_rdata, 32'h0f1e_2d3c);
    dop(1'b1, 1'b0, 16'h1234, 2'h2, 4'h5, 32'h1122_3344);
    dop(1'b0, 1'b0, 16'h1234, 2'h2, 4'h0, 32'h0);
    chk(data_rsp_rdata, 32'ha522_5a44);
    dop(1'b0, 1'b0, 16'h1234, 2'h1, 4'h0, 32'h0);
    chk(data_rsp_rdata, 32'h7777_0000);
  endtask
  task automatic t_tag;
    top(1'b1, 16'h0042, 9'h1a5, 1'b1, 1'b1);
    top(1'b1, 16'h0043, 9'h05a, 1'b0, 1'b0);
    top(1'b0, 16'h0042, 9'h0, 1'b0, 1'b0);
    chk({21'h0, tag_rsp_modified, tag_rsp_valid_bit, tag_rsp_tag}, 32'h7a5);
    top(1'b0, 16'h0043, 9'h0, 1'b0, 1'b0);
    chk({21'h0, tag_rsp_modified, tag_rsp_valid_bit, tag_rsp_tag}, 32'h05a);
    presence_detect = 5'h11;
    repeat (2) @(negedge clk);
    top(1'b0, 16'h0042, 9'h0, 1'b0, 1'b0);
    chk({23'h0, tag_rsp_tag}, 32'h025);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    n_fail = 0;
    checks = 0;
    reset_n = 1'b0;
    data_req_valid = 1'b0;
    tag_req_valid = 1'b0;
    data_req = '0;
    tag_req = '0;
    tag_req_addr = 16'h0;
    presence_detect = 5'h00;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_cfg;
    t_data;
    t_tag;
    tally_and_finish;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
endmodule
bind scsm_ctrl scsm_ctrl_monitor u_mon (.*);
`default_nettype wire

//--- rtl/scsm_cfg.svh
`ifndef SCSM_CFG_SVH
`define SCSM_CFG_SVH
`define SCSM_CLK_PERIOD_NS   20
`define SCSM_CYCLE_NS        30
`define SCSM_CYCLE_CLKS      ((`SCSM_CYCLE_NS + `SCSM_CLK_PERIOD_NS - 1) / `SCSM_CLK_PERIOD_NS)
`define SCSM_PD_FITTED       4
`define SCSM_PD_MEM_X4       3
`define SCSM_PD_MEM_X1       2
`define SCSM_PD_256K         1
`define SCSM_PD_128K         0
`define SCSM_ALE_PASS        1'b1
`define SCSM_ALE_HOLD        1'b0
`define SCSM_TAG_W7          2'h0
`define SCSM_TAG_W8          2'h1
`define SCSM_TAG_W9          2'h2
`define SCSM_CNT_ZERO        2'h0
`endif

//--- rtl/scsm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsm_cfg.svh"
module scsm_ctrl (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   data_req_valid,
  output logic                        data_req_ready,
  input  wire scsm_pkg::scsm_data_req_t data_req,
  output logic                        data_rsp_valid,
  output logic [31:0]                 data_rsp_rdata,
  input  wire logic                   tag_req_valid,
  output logic                        tag_req_ready,
  input  wire scsm_pkg::scsm_tag_req_t tag_req,
  input  wire logic [15:0]            tag_req_addr,
  output logic                        tag_rsp_valid,
  output logic [8:0]                  tag_rsp_tag,
  output logic                        tag_rsp_valid_bit,
  output logic                        tag_rsp_modified,
  output scsm_pkg::scsm_cfg_t         cfg,
  input  wire logic [4:0]             presence_detect,
  output logic [15:0]                 shared_address,
  output logic [1:0]                  upper_bank_low_address,
  output logic [1:0]                  lower_bank_low_address,
  output logic                        addr_latch_enable,
  output logic                        bank_low_chip_enable_n,
  output logic                        bank_high_chip_enable_n,
  output logic                        bank_low_output_enable_n,
  output logic                        bank_high_output_enable_n,
  output logic [3:0]                  byte_write_enable_n,
  input  wire logic [31:0]            cache_data_i,
  output logic [31:0]                 cache_data_o,
  output logic                        cache_data_oe,
  output logic                        tag_chip_enable_n,
  output logic                        tag_write_enable_n,
  output logic                        tag_output_enable_n,
  input  wire logic [8:0]             tag_data_i,
  output logic [8:0]                  tag_data_o,
  output logic                        tag_data_oe,
  input  wire logic                   valid_bit_i,
  output logic                        valid_bit_o,
  output logic                        valid_bit_oe,
  output logic                        modified_chip_enable_n,
  output logic                        modified_write_enable_n,
  output logic                        modified_data_in,
  input  wire logic                   modified_data_out
);
  import scsm_pkg::*;

  typedef enum logic [1:0] {
    SCSM_IDLE = 2'h0,
    SCSM_DATA = 2'h1,
    SCSM_TAG  = 2'h2
  } scsm_state_t;

  scsm_state_t    state_q;
  logic [1:0]     cnt_q;
  scsm_data_req_t dreq_q;
  scsm_tag_req_t  treq_q;
  logic [8:0]     tag_mask;
  logic           last;

  scsm_pd_decode u_pd (
    .clk             (clk),
    .reset_n         (reset_n),
    .presence_detect (presence_detect),
    .cfg             (cfg)
  );

  // absent tag bits are driven low and read back as zero
  always_comb begin
    unique case (cfg.tag_width)
      `SCSM_TAG_W7: tag_mask = 9'h07f;
      `SCSM_TAG_W8: tag_mask = 9'h0ff;
      default:      tag_mask = 9'h1ff;
    endcase
  end

  assign last           = (cnt_q == `SCSM_CNT_ZERO);
  // requests stall when no module is fitted
  assign data_req_ready = (state_q == SCSM_IDLE) && cfg.fitted;
  assign tag_req_ready  = (state_q == SCSM_IDLE) && cfg.fitted && !data_req_valid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SCSM_IDLE;
      cnt_q   <= `SCSM_CNT_ZERO;
    end else begin
      unique case (state_q)
        SCSM_IDLE: begin
          cnt_q <= 2'(`SCSM_CYCLE_CLKS - 1);
          if (data_req_valid && data_req_ready) begin
            state_q <= SCSM_DATA;
          end else if (tag_req_valid && tag_req_ready) begin
            state_q <= SCSM_TAG;
          end
        end
        SCSM_DATA, SCSM_TAG: begin
          // strobes stand one clock; read data is taken as they drop, next take follows
          if (last) begin
            state_q <= SCSM_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'h1;
          end
        end
        default: state_q <= SCSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dreq_q <= '0;
      treq_q <= '0;
    end else if (state_q == SCSM_IDLE) begin
      if (data_req_valid && data_req_ready) begin
        dreq_q <= data_req;
      end
      if (tag_req_valid && tag_req_ready) begin
        treq_q <= tag_req;
        dreq_q.addr <= tag_req_addr;
      end
    end
  end

  // address latch opens the clock after each idle cycle and shuts on the same edge that asserts the strobes, so the arrays see a steady address
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_latch_enable      <= `SCSM_ALE_HOLD;
      shared_address         <= '0;
      upper_bank_low_address <= '0;
      lower_bank_low_address <= '0;
    end else if (state_q == SCSM_IDLE) begin
      addr_latch_enable <= `SCSM_ALE_PASS;
      if (data_req_valid && data_req_ready) begin
        shared_address         <= data_req.addr;
        upper_bank_low_address <= data_req.addr_lo;
        lower_bank_low_address <= data_req.addr_lo;
      end else if (tag_req_valid && tag_req_ready) begin
        shared_address <= tag_req_addr;
      end
    end else begin
      addr_latch_enable <= `SCSM_ALE_HOLD;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bank_low_chip_enable_n    <= 1'b1;
      bank_high_chip_enable_n   <= 1'b1;
      bank_low_output_enable_n  <= 1'b1;
      bank_high_output_enable_n <= 1'b1;
      byte_write_enable_n       <= 4'hf;
      cache_data_o              <= '0;
      cache_data_oe             <= 1'b0;
    end else if (state_q == SCSM_DATA && !last) begin
      bank_low_chip_enable_n    <= dreq_q.bank_high;
      bank_high_chip_enable_n   <= !dreq_q.bank_high;
      bank_low_output_enable_n  <= dreq_q.write || dreq_q.bank_high;
      bank_high_output_enable_n <= dreq_q.write || !dreq_q.bank_high;
      byte_write_enable_n       <= dreq_q.write ? ~dreq_q.byte_en : 4'hf;
      cache_data_o              <= dreq_q.wdata;
      cache_data_oe             <= dreq_q.write;
    end else begin
      bank_low_chip_enable_n    <= 1'b1;
      bank_high_chip_enable_n   <= 1'b1;
      bank_low_output_enable_n  <= 1'b1;
      bank_high_output_enable_n <= 1'b1;
      byte_write_enable_n       <= 4'hf;
      cache_data_oe             <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tag_chip_enable_n       <= 1'b1;
      tag_write_enable_n      <= 1'b1;
      tag_output_enable_n     <= 1'b1;
      tag_data_o              <= '0;
      tag_data_oe             <= 1'b0;
      valid_bit_o             <= 1'b0;
      valid_bit_oe            <= 1'b0;
      modified_chip_enable_n  <= 1'b1;
      modified_write_enable_n <= 1'b1;
      modified_data_in        <= 1'b0;
    end else if (state_q == SCSM_TAG && !last) begin
      tag_chip_enable_n       <= 1'b0;
      tag_write_enable_n      <= !treq_q.write;
      tag_output_enable_n     <= treq_q.write;
      tag_data_o              <= treq_q.tag & tag_mask;
      tag_data_oe             <= treq_q.write;
      valid_bit_o             <= treq_q.valid;
      valid_bit_oe            <= treq_q.write;
      modified_chip_enable_n  <= 1'b0;
      modified_write_enable_n <= !treq_q.write;
      modified_data_in        <= treq_q.modified;
    end else begin
      tag_chip_enable_n       <= 1'b1;
      tag_write_enable_n      <= 1'b1;
      tag_output_enable_n     <= 1'b1;
      tag_data_oe             <= 1'b0;
      valid_bit_oe            <= 1'b0;
      modified_chip_enable_n  <= 1'b1;
      modified_write_enable_n <= 1'b1;
    end
  end

  // read data captured at the end of the strobe, when access time has passed
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_rsp_valid    <= 1'b0;
      data_rsp_rdata    <= '0;
      tag_rsp_valid     <= 1'b0;
      tag_rsp_tag       <= '0;
      tag_rsp_valid_bit <= 1'b0;
      tag_rsp_modified  <= 1'b0;
    end else begin
      data_rsp_valid <= 1'b0;
      tag_rsp_valid  <= 1'b0;
      if (state_q == SCSM_DATA && last) begin
        data_rsp_valid <= 1'b1;
        if (!dreq_q.write) begin
          data_rsp_rdata <= cache_data_i;
        end
      end
      if (state_q == SCSM_TAG && last) begin
        tag_rsp_valid <= 1'b1;
        if (!treq_q.write) begin
          tag_rsp_tag       <= tag_data_i & tag_mask;
          tag_rsp_valid_bit <= valid_bit_i;
          tag_rsp_modified  <= modified_data_out;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/scsm_pd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "scsm_cfg.svh"
module scsm_pd_decode (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [4:0]        presence_detect,
  output scsm_pkg::scsm_cfg_t    cfg
);
  import scsm_pkg::*;
  scsm_cfg_t cfg_d;
  always_comb begin
    cfg_d = '0;
    cfg_d.fitted = presence_detect[`SCSM_PD_FITTED];
    unique case ({presence_detect[`SCSM_PD_256K], presence_detect[`SCSM_PD_128K]})
      2'h1:    cfg_d.size = SCSM_SZ_128K;
      2'h2:    cfg_d.size = SCSM_SZ_256K;
      2'h0:    cfg_d.size = SCSM_SZ_NONE;
      default: cfg_d.size = SCSM_SZ_BAD;
    endcase
    unique case ({presence_detect[`SCSM_PD_MEM_X4], presence_detect[`SCSM_PD_MEM_X1]})
      2'h2:    cfg_d.mem = SCSM_MEM_X1;
      2'h0:    cfg_d.mem = SCSM_MEM_X2;
      2'h1:    cfg_d.mem = SCSM_MEM_X4;
      default: cfg_d.mem = SCSM_MEM_BAD;
    endcase
    // smallest memory lacks bit 8, middle lacks bits 7 and 8
    unique case (cfg_d.mem)
      SCSM_MEM_X1: cfg_d.tag_width = `SCSM_TAG_W8;
      SCSM_MEM_X2: cfg_d.tag_width = `SCSM_TAG_W7;
      default:     cfg_d.tag_width = `SCSM_TAG_W9;
    endcase
    if (!cfg_d.fitted) begin
      cfg_d = '0;
    end
  end
  // straps are static, so they are re-sampled each cycle after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/scsm_pkg.sv
package scsm_pkg;
  typedef enum logic [1:0] {
    SCSM_SZ_NONE = 2'h0,
    SCSM_SZ_128K = 2'h1,
    SCSM_SZ_256K = 2'h2,
    SCSM_SZ_BAD  = 2'h3
  } scsm_size_t;
  typedef enum logic [1:0] {
    SCSM_MEM_X1  = 2'h0,
    SCSM_MEM_X2  = 2'h1,
    SCSM_MEM_X4  = 2'h2,
    SCSM_MEM_BAD = 2'h3
  } scsm_mem_t;
  typedef struct packed {
    scsm_size_t size;
    scsm_mem_t  mem;
    logic [1:0] tag_width;
    logic       fitted;
  } scsm_cfg_t;
  typedef struct packed {
    logic [31:0] wdata;
    logic [15:0] addr;
    logic [1:0]  addr_lo;
    logic [3:0]  byte_en;
    logic        bank_high;
    logic        write;
  } scsm_data_req_t;
  typedef struct packed {
    logic [8:0]  tag;
    logic        valid;
    logic        modified;
    logic        write;
  } scsm_tag_req_t;
endpackage
